// ===== logic/pwm_timer_pkg.sv
// package for the master/slave pwm timer: register map, reset values, bus carriers
// assumes a 12-bit axi4-lite byte address and 32-bit data
package pwm_timer_pkg;

  // unit and channel counts, counter width, prescaler limit and slow-clock channel
  localparam int UNITS    = 2;
  localparam int CHANS    = 8;
  localparam int CNT_W    = 16;
  localparam int DIV_MAX  = 15;
  localparam int SUB_CHAN = 5;

  // count clock selections beyond the prescaler taps
  localparam logic [4:0] SEL_SUB = 5'h10;
  localparam logic [4:0] SEL_LS  = 5'h11;

  // address pages: page 0 global, one page per unit
  localparam logic [3:0] GLOBAL_PAGE = 4'h0;
  localparam logic [3:0] UNIT_PAGE0  = 4'h1;

  // offsets within a page
  localparam logic [7:0] OFF_PER_EN = 8'h00;
  localparam logic [7:0] OFF_START  = 8'h00;
  localparam logic [7:0] OFF_STOP   = 8'h04;
  localparam logic [7:0] OFF_MODE   = 8'h08;
  localparam logic [7:0] OFF_OE     = 8'h0C;
  localparam logic [7:0] OFF_LVL    = 8'h10;
  localparam logic [7:0] OFF_POL    = 8'h14;
  localparam logic [7:0] OFF_PORT   = 8'h18;
  // per-channel banks, selected by offset bits 7:5, channel in bits 4:2
  localparam logic [2:0] BANK_CMP   = 3'h2;
  localparam logic [2:0] BANK_CNT   = 3'h3;
  localparam logic [2:0] BANK_CSEL  = 3'h4;

  // reset values
  localparam logic [15:0] RST_CMP   = 16'h0000;
  localparam logic [4:0]  RST_CSEL  = 5'h00;
  localparam logic [7:0]  RST_PDIR  = 8'hFF;
  localparam logic [7:0]  RST_DRV_N = 8'hFF;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

endpackage

// ===== logic/pwm_timer_array.sv
// two timer units of eight down-counting channels, master/slave pwm, axi4-lite registers
// assumes slow clock pins are asynchronous and much slower than aclk
//
// Notes on behaviour
// R1: unit runs only when its enable bit set
// R2: count clock divides aclk by 2^0..2^15
// R3: sub and low-speed clocks only on channel 5
// R4: period equals master compare plus one
// R5: active-high width equals slave compare
// R6: active-low width is period minus slave compare
// R7: master interrupt also fires at start
// R8: master interrupt on tick after zero
// R9: slave interrupt on tick after zero
// R10: new compares apply at master interrupt
// R11: software rewrites master compare only for period
// R12: start trigger bit begins counting
// R13: stop trigger bit halts counting
// R14: counters readable at any time
// R15: output-level bit drives pin when disabled
// R16: software sets level bit after port enable
// R17: start drives slave output to active level
// R18: pulse reaches pin only with port bits zero
// R19: masters even channels, slaves above master
// R20: two identical units with own registers
// R21: master interrupt reloads and restarts slaves
`timescale 1ns/1ps
module pwm_timer_array #(
  parameter int CNT_W = pwm_timer_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // register bus
  input  wire pwm_timer_pkg::axi_req_s  axi_req,
  output pwm_timer_pkg::axi_rsp_s       axi_rsp,
  // alternative count clock pins
  input  wire logic                     subsystem_clock,
  input  wire logic                     low_speed_internal_clock,
  // pins and events per unit
  output logic [1:0][7:0]               slave_output_pin,
  output logic [1:0][7:0]               pin_drive_n,
  output logic [1:0][7:0]               channel_period_irq
);

  localparam int NU = pwm_timer_pkg::UNITS;
  localparam int NC = pwm_timer_pkg::CHANS;
  localparam int PW = pwm_timer_pkg::DIV_MAX;

  typedef struct packed {
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] cnt;
    logic [4:0]       csel;
    logic             run;
    logic             armed;
    logic             act;
  } chan_s;

  typedef struct packed {
    logic [PW-1:0]        pre;
    logic [1:0]           msel;
    logic [NC-1:0]        slv;
    logic [NC-1:0]        oe;
    logic [NC-1:0]        lvl;
    logic [NC-1:0]        pol;
    logic [NC-1:0]        pdir;
    logic [NC-1:0]        plat;
    logic [NC-1:0]        pana;
    logic [NC-1:0]        pin;
    logic [NC-1:0]        drv_n;
    logic [NC-1:0]        irq;
    chan_s [NC-1:0]       ch;
  } unit_s;

  typedef struct packed {
    logic [NU-1:0]        per_en;
    unit_s [NU-1:0]       u;
    logic                 aw_held;
    logic [11:0]          awaddr;
    logic                 w_held;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [2:0]           sub_s;
    logic [2:0]           ls_s;
    logic                 sub_st;
    logic                 ls_st;
  } state_s;

  state_s               st_r;
  state_s               st_nxt;
  logic                 do_wr;
  logic [31:0]          wmask;
  logic [31:0]          wtrig;
  logic [3:0]           wpage;
  logic [7:0]           woff;
  logic                 sub_edge;
  logic                 ls_edge;
  logic [NU-1:0]        mirq;
  logic [NU-1:0][NC-1:0] startv;
  logic [NU-1:0][NC-1:0] stopv;
  logic [NU-1:0][NC-1:0] tick;
  logic [NU-1:0][2:0]   mch;
  logic [PW-1:0]        pmask;
  logic                 pgate;

  function automatic logic addr_hit(input logic [11:0] a);
    logic [3:0] pg;
    logic [7:0] of;
    pg = a[11:8];
    of = a[7:0];
    addr_hit = 1'b0;
    if (pg == pwm_timer_pkg::GLOBAL_PAGE && of == pwm_timer_pkg::OFF_PER_EN) begin
      addr_hit = 1'b1;
    end
    for (int ui = 0; ui < NU; ui++) begin
      if (pg == 4'(pwm_timer_pkg::UNIT_PAGE0 + ui)) begin
        if (of <= pwm_timer_pkg::OFF_PORT && of[1:0] == 2'h0) begin
          addr_hit = 1'b1;
        end
        if (of[7:5] == pwm_timer_pkg::BANK_CMP || of[7:5] == pwm_timer_pkg::BANK_CNT ||
            of[7:5] == pwm_timer_pkg::BANK_CSEL) begin
          addr_hit = 1'b1;
        end
      end
    end
  endfunction

  function automatic logic [31:0] rd_word(input state_s s, input logic [11:0] a);
    logic [3:0] pg;
    logic [7:0] of;
    logic [2:0] c;
    pg = a[11:8];
    of = a[7:0];
    c = a[4:2];
    rd_word = 32'h0000_0000;
    if (pg == pwm_timer_pkg::GLOBAL_PAGE && of == pwm_timer_pkg::OFF_PER_EN) begin
      rd_word[NU-1:0] = s.per_en;
    end
    for (int ui = 0; ui < NU; ui++) begin
      if (pg == 4'(pwm_timer_pkg::UNIT_PAGE0 + ui)) begin
        case (of)
          // running flags read back at the start trigger address
          pwm_timer_pkg::OFF_START: begin
            for (int n = 0; n < NC; n++) begin
              rd_word[n] = s.u[ui].ch[n].run;
            end
          end
          pwm_timer_pkg::OFF_MODE: begin
            rd_word[1:0] = s.u[ui].msel;
            rd_word[15:8] = s.u[ui].slv;
          end
          pwm_timer_pkg::OFF_OE: rd_word[7:0] = s.u[ui].oe;
          pwm_timer_pkg::OFF_LVL: rd_word[7:0] = s.u[ui].lvl;
          pwm_timer_pkg::OFF_POL: rd_word[7:0] = s.u[ui].pol;
          pwm_timer_pkg::OFF_PORT: rd_word[23:0] = {s.u[ui].pana, s.u[ui].plat, s.u[ui].pdir};
          default: begin
            if (of[7:5] == pwm_timer_pkg::BANK_CMP) begin
              rd_word[CNT_W-1:0] = s.u[ui].ch[c].cmp;
            end
            // R14: live counter read
            if (of[7:5] == pwm_timer_pkg::BANK_CNT) begin
              rd_word[CNT_W-1:0] = s.u[ui].ch[c].cnt;
            end
            if (of[7:5] == pwm_timer_pkg::BANK_CSEL) begin
              rd_word[4:0] = s.u[ui].ch[c].csel;
            end
          end
        endcase
      end
    end
  endfunction

  always_comb begin
    st_nxt = st_r;
    do_wr = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    wmask = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}}, {8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    wtrig = st_r.wdata & wmask;
    wpage = st_r.awaddr[11:8];
    woff = st_r.awaddr[7:0];
    mirq = '0;
    startv = '0;
    stopv = '0;
    tick = '0;
    mch = '0;
    pmask = '0;
    pgate = 1'b0;

    // bus write side: address and data held independently, answer follows both
    if (axi_req.awvalid && !st_r.aw_held && !st_r.bvalid) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_r.w_held && !st_r.bvalid) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = axi_req.wdata;
      st_nxt.wstrb = axi_req.wstrb;
    end
    if (st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_hit(st_r.awaddr) ? pwm_timer_pkg::RESP_OKAY
                                           : pwm_timer_pkg::RESP_SLVERR;
    end

    // bus read side: one read at a time, data sampled at the address handshake
    if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word(st_r, axi_req.araddr);
      st_nxt.rresp = addr_hit(axi_req.araddr) ? pwm_timer_pkg::RESP_OKAY
                                              : pwm_timer_pkg::RESP_SLVERR;
    end

    // slow clock pins: three stages, an edge counts once stages two and three agree
    st_nxt.sub_s = {st_r.sub_s[1:0], subsystem_clock};
    st_nxt.ls_s = {st_r.ls_s[1:0], low_speed_internal_clock};
    sub_edge = (st_r.sub_s[2] == st_r.sub_s[1]) && st_r.sub_s[2] && !st_r.sub_st;
    ls_edge = (st_r.ls_s[2] == st_r.ls_s[1]) && st_r.ls_s[2] && !st_r.ls_st;
    if (st_r.sub_s[2] == st_r.sub_s[1]) begin
      st_nxt.sub_st = st_r.sub_s[2];
    end
    if (st_r.ls_s[2] == st_r.ls_s[1]) begin
      st_nxt.ls_st = st_r.ls_s[2];
    end

    if (do_wr && wpage == pwm_timer_pkg::GLOBAL_PAGE && woff == pwm_timer_pkg::OFF_PER_EN) begin
      st_nxt.per_en = (st_r.per_en & ~wmask[NU-1:0]) | (st_r.wdata[NU-1:0] & wmask[NU-1:0]);
    end

    // R20: identical units, each with its own page
    for (int u = 0; u < NU; u++) begin
      // R1: a unit without its enable neither counts nor takes writes
      st_nxt.u[u].pre = st_r.per_en[u] ? st_r.u[u].pre + 1'b1 : '0;
      if (do_wr && st_r.per_en[u] && wpage == 4'(pwm_timer_pkg::UNIT_PAGE0 + u)) begin
        case (woff)
          // R12: start trigger
          pwm_timer_pkg::OFF_START: startv[u] = wtrig[NC-1:0];
          // R13: stop trigger
          pwm_timer_pkg::OFF_STOP: stopv[u] = wtrig[NC-1:0];
          pwm_timer_pkg::OFF_MODE: begin
            if (st_r.wstrb[0]) begin
              st_nxt.u[u].msel = st_r.wdata[1:0];
            end
            if (st_r.wstrb[1]) begin
              st_nxt.u[u].slv = st_r.wdata[15:8];
            end
          end
          pwm_timer_pkg::OFF_OE: begin
            if (st_r.wstrb[0]) begin
              st_nxt.u[u].oe = st_r.wdata[7:0];
            end
          end
          // R15: level bits only change while the timer output is disabled
          pwm_timer_pkg::OFF_LVL: begin
            if (st_r.wstrb[0]) begin
              st_nxt.u[u].lvl = (st_r.u[u].lvl & st_r.u[u].oe) |
                                (st_r.wdata[7:0] & ~st_r.u[u].oe);
            end
          end
          pwm_timer_pkg::OFF_POL: begin
            if (st_r.wstrb[0]) begin
              st_nxt.u[u].pol = st_r.wdata[7:0];
            end
          end
          pwm_timer_pkg::OFF_PORT: begin
            if (st_r.wstrb[0]) begin
              st_nxt.u[u].pdir = st_r.wdata[7:0];
            end
            if (st_r.wstrb[1]) begin
              st_nxt.u[u].plat = st_r.wdata[15:8];
            end
            if (st_r.wstrb[2]) begin
              st_nxt.u[u].pana = st_r.wdata[23:16];
            end
          end
          default: begin
            // R10: compare only buffered here, sampled at the master interrupt
            if (woff[7:5] == pwm_timer_pkg::BANK_CMP) begin
              st_nxt.u[u].ch[woff[4:2]].cmp = CNT_W'((st_r.u[u].ch[woff[4:2]].cmp & ~wmask) |
                                                     (st_r.wdata & wmask));
            end
            if (woff[7:5] == pwm_timer_pkg::BANK_CSEL && st_r.wstrb[0]) begin
              st_nxt.u[u].ch[woff[4:2]].csel = st_r.wdata[4:0];
            end
          end
        endcase
      end

      // R19: master on an even channel
      mch[u] = {st_r.u[u].msel, 1'b0};
      for (int n = 0; n < NC; n++) begin
        pmask = PW'((32'h0000_0001 << st_r.u[u].ch[n].csel[3:0]) - 32'h0000_0001);
        if (st_r.per_en[u]) begin
          // R2: prescaler taps 2^0 to 2^15
          if (!st_r.u[u].ch[n].csel[4]) begin
            tick[u][n] = (st_r.u[u].pre & pmask) == pmask;
          end
          // R3: slow sources exist on one channel only
          if (n == pwm_timer_pkg::SUB_CHAN && st_r.u[u].ch[n].csel == pwm_timer_pkg::SEL_SUB) begin
            tick[u][n] = sub_edge;
          end
          if (n == pwm_timer_pkg::SUB_CHAN && st_r.u[u].ch[n].csel == pwm_timer_pkg::SEL_LS) begin
            tick[u][n] = ls_edge;
          end
        end
        if (stopv[u][n]) begin
          st_nxt.u[u].ch[n].run = 1'b0;
          st_nxt.u[u].ch[n].armed = 1'b0;
        end else if (startv[u][n]) begin
          st_nxt.u[u].ch[n].run = 1'b1;
        end
      end

      st_nxt.u[u].irq = '0;
      // master channel
      for (int n = 0; n < NC; n++) begin
        if (3'(n) == mch[u] && !stopv[u][n]) begin
          if (startv[u][n]) begin
            // R7: interrupt at start
            st_nxt.u[u].ch[n].cnt = st_r.u[u].ch[n].cmp;
            mirq[u] = 1'b1;
          end else if (st_r.u[u].ch[n].run && tick[u][n]) begin
            // R4: reload after zero gives compare plus one ticks
            // R8: interrupt on the tick after zero
            if (st_r.u[u].ch[n].cnt == '0) begin
              st_nxt.u[u].ch[n].cnt = st_r.u[u].ch[n].cmp;
              mirq[u] = 1'b1;
            end else begin
              st_nxt.u[u].ch[n].cnt = st_r.u[u].ch[n].cnt - 1'b1;
            end
          end
          st_nxt.u[u].irq[n] = mirq[u];
        end
      end

      // slave channels
      for (int n = 0; n < NC; n++) begin
        if (3'(n) > mch[u] && st_r.u[u].slv[n] && !stopv[u][n]) begin
          // R17: output goes active at start
          if (startv[u][n]) begin
            st_nxt.u[u].ch[n].act = 1'b1;
          end
          if ((st_r.u[u].ch[n].run || startv[u][n]) && mirq[u]) begin
            // R21: reload, restart and go active on master interrupt, or go inactive when the slave compare is zero
            // R5: loading compare minus one holds active for compare ticks
            if (st_r.u[u].ch[n].cmp == '0) begin
              st_nxt.u[u].ch[n].act = 1'b0;
              st_nxt.u[u].ch[n].armed = 1'b0;
            end else begin
              st_nxt.u[u].ch[n].cnt = st_r.u[u].ch[n].cmp - 1'b1;
              st_nxt.u[u].ch[n].act = 1'b1;
              st_nxt.u[u].ch[n].armed = 1'b1;
            end
          end else if (st_r.u[u].ch[n].run && st_r.u[u].ch[n].armed && tick[u][n]) begin
            // R9: slave interrupt on tick after zero
            if (st_r.u[u].ch[n].cnt == '0) begin
              st_nxt.u[u].ch[n].act = 1'b0;
              st_nxt.u[u].ch[n].armed = 1'b0;
              st_nxt.u[u].irq[n] = 1'b1;
            end else begin
              st_nxt.u[u].ch[n].cnt = st_r.u[u].ch[n].cnt - 1'b1;
            end
          end
        end
      end

      // pins
      for (int n = 0; n < NC; n++) begin
        // R18: pulse reaches the pin only with all port bits clear
        pgate = st_nxt.u[u].pdir[n] | st_nxt.u[u].plat[n] | st_nxt.u[u].pana[n];
        st_nxt.u[u].drv_n[n] = st_nxt.u[u].pdir[n] | st_nxt.u[u].pana[n];
        if (pgate) begin
          st_nxt.u[u].pin[n] = st_nxt.u[u].plat[n];
        end else if (st_nxt.u[u].oe[n]) begin
          // R6: inverted polarity turns the active width low
          st_nxt.u[u].pin[n] = st_nxt.u[u].ch[n].act ^ st_nxt.u[u].pol[n];
        end else begin
          // R15: level bit drives the pin while output disabled
          st_nxt.u[u].pin[n] = st_nxt.u[u].lvl[n];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      for (int u = 0; u < NU; u++) begin
        st_r.u[u].pdir <= pwm_timer_pkg::RST_PDIR;
        st_r.u[u].drv_n <= pwm_timer_pkg::RST_DRV_N;
        for (int n = 0; n < NC; n++) begin
          st_r.u[u].ch[n].cmp <= CNT_W'(pwm_timer_pkg::RST_CMP);
          st_r.u[u].ch[n].csel <= pwm_timer_pkg::RST_CSEL;
        end
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // handshakes combinational, data from flops
  always_comb begin
    axi_rsp.awready = !st_r.aw_held && !st_r.bvalid;
    axi_rsp.wready = !st_r.w_held && !st_r.bvalid;
    axi_rsp.bvalid = st_r.bvalid;
    axi_rsp.bresp = st_r.bresp;
    axi_rsp.arready = !st_r.rvalid;
    axi_rsp.rvalid = st_r.rvalid;
    axi_rsp.rdata = st_r.rdata;
    axi_rsp.rresp = st_r.rresp;
    for (int u = 0; u < NU; u++) begin
      slave_output_pin[u] = st_r.u[u].pin;
      pin_drive_n[u] = st_r.u[u].drv_n;
      channel_period_irq[u] = st_r.u[u].irq;
    end
  end

endmodule

// ===== verif/pwm_timer_checker.sv
// checker for pwm_timer_array: bus handshake, reset state and pin handover timing
// assumes it is bound to pwm_timer_array and sees only its ports on one aclk domain
`timescale 1ns/1ps
module pwm_timer_checker (
  // clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // register bus
  input wire pwm_timer_pkg::axi_req_s axi_req,
  input wire pwm_timer_pkg::axi_rsp_s axi_rsp,
  // slow clocks and pins
  input wire logic                    subsystem_clock,
  input wire logic                    low_speed_internal_clock,
  input wire logic [1:0][7:0]         slave_output_pin,
  input wire logic [1:0][7:0]         pin_drive_n,
  input wire logic [1:0][7:0]         channel_period_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_state_a: assert property (
    $rose(aresetn) |-> channel_period_irq == '0 && pin_drive_n == '1 && slave_output_pin == '0)
    else $error("outputs not at reset level after reset");
  read_latency_a: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data not one cycle after address");
  read_block_a: assert property (
    axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken while data pending");
  read_answer_a: assert property (
    axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid && axi_rsp.arready)
    else $error("read channel not free after handshake");
  write_latency_a: assert property (
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response not two cycles after address and data");
  write_block_a: assert property (
    axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while response pending");
  write_release_a: assert property (
    axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
    else $error("write channel not free after response");
  // pin ownership only moves through a register write
  drive_change_a: assert property (
    !$stable(pin_drive_n) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid))
    else $error("pin drive changed without a write");
endmodule

bind pwm_timer_array pwm_timer_checker chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .subsystem_clock(subsystem_clock), .low_speed_internal_clock(low_speed_internal_clock),
  .slave_output_pin(slave_output_pin), .pin_drive_n(pin_drive_n),
  .channel_period_irq(channel_period_irq));

// ===== verif/pwm_load.sv
// external load model: times the high phase and the period of one timer pin
// assumes the pin settles well before the falling edge of aclk
`timescale 1ns/1ps
module pwm_load (
  // clock
  input  wire logic  aclk,
  // watched pin
  input  wire logic  pin,
  input  wire logic  drive_n,
  // last full lengths in aclk cycles
  output logic [15:0] high_len,
  output logic [15:0] period_len
);
  logic        prev_r = 1'h0;
  logic [15:0] cnt_r  = 16'h0000;
  // an undriven pin reads low through the load's pull-down
  wire  logic  seen = pin & ~drive_n;

  // sampled mid-cycle so the pin's launching edge never races the count
  always @(negedge aclk) begin
    prev_r <= seen;
    cnt_r  <= (seen && !prev_r) ? 16'h0001 : cnt_r + 16'h0001;
    if (seen && !prev_r) period_len <= cnt_r;
    if (!seen && prev_r) high_len <= cnt_r;
  end
endmodule

// ===== verif/master_slave_pwm_timer_tb_top.sv
// bench for pwm_timer_array: register rows, then pwm timing of unit 0 (master 0, slave 1)
// assumes the checker binds itself and pwm_load watches unit 0 channel 1
`timescale 1ns/1ps
module master_slave_pwm_timer_tb_top;
  localparam logic [1:0] OKR = pwm_timer_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pwm_timer_pkg::RESP_SLVERR;
  typedef struct {
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] back;
    logic [1:0]  resp;
    logic [7:0]  pins;
  } row_s;

  logic                    aclk     = 1'h0;
  logic                    aresetn  = 1'h0;
  pwm_timer_pkg::axi_req_s req      = '0;
  pwm_timer_pkg::axi_rsp_s rsp;
  logic                    sub_clk  = 1'h0;
  logic                    ls_clk   = 1'h0;
  logic [1:0][7:0]         pin;
  logic [1:0][7:0]         drv_n;
  logic [1:0][7:0]         irq;
  logic [15:0]             high_len;
  logic [15:0]             period_len;
  logic [31:0]             rd;
  logic [1:0]              wresp;
  logic [1:0]              rresp;
  logic                    start_hi = 1'h0;
  int                      n_fail   = 0;
  int                      checked  = 0;
  int                      cyc      = 0;
  int                      m_cnt    = 0;
  int                      m_last   = 0;
  int                      m_gap    = 0;
  int                      s_gap    = 0;
  int                      m_hold;

  row_s rows [9] = '{
    '{12'h140, 32'h0000_0009, 32'h0000_0000, OKR, 8'h00},
    '{12'h000, 32'h0000_0001, 32'h0000_0001, OKR, 8'h00},
    '{12'h118, 32'h0000_0000, 32'h0000_0000, OKR, 8'h00},
    '{12'h110, 32'h0000_0002, 32'h0000_0002, OKR, 8'h02},
    '{12'h140, 32'h0000_0009, 32'h0000_0009, OKR, 8'h02},
    '{12'h144, 32'h0000_0003, 32'h0000_0003, OKR, 8'h02},
    '{12'h108, 32'h0000_0200, 32'h0000_0200, OKR, 8'h02},
    '{12'h240, 32'h0000_0007, 32'h0000_0000, OKR, 8'h02},
    '{12'h300, 32'h0000_0005, 32'h0000_0000, ERR, 8'h02}
  };

  always #4 aclk = ~aclk;
  always #100 sub_clk = ~sub_clk;
  always #170 ls_clk = ~ls_clk;

  pwm_timer_array DUT (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .subsystem_clock(sub_clk), .low_speed_internal_clock(ls_clk),
    .slave_output_pin(pin), .pin_drive_n(drv_n), .channel_period_irq(irq));

  pwm_load load (.aclk(aclk), .pin(pin[0][1]), .drive_n(drv_n[0][1]),
    .high_len(high_len), .period_len(period_len));

  // interrupt spacing, read mid-cycle to stay clear of the launching edge
  always @(negedge aclk) begin
    if (irq[0][0]) begin
      m_gap  <= cyc - m_last;
      m_last <= cyc;
      m_cnt  <= m_cnt + 1;
    end
    if (irq[0][1]) s_gap <= cyc - m_last;
    if (m_cnt == 1 && pin[0][1]) start_hi <= 1'h1;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // channels are judged mid-cycle and released after the edge that takes them
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    b = 1'h0;
    @(posedge aclk);
    req.awvalid <= 1'h1;
    req.awaddr  <= a;
    req.wvalid  <= 1'h1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'h1;
    while (!b) begin
      @(negedge aclk);
      aw    = req.awvalid && rsp.awready;
      w     = req.wvalid && rsp.wready;
      b     = rsp.bvalid;
      wresp = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'h0;
      if (w) req.wvalid <= 1'h0;
      if (b) req.bready <= 1'h0;
    end
  endtask

  task automatic rdr(input logic [11:0] a);
    logic ar;
    logic r;
    r = 1'h0;
    @(posedge aclk);
    req.arvalid <= 1'h1;
    req.araddr  <= a;
    req.rready  <= 1'h1;
    while (!r) begin
      @(negedge aclk);
      ar    = req.arvalid && rsp.arready;
      r     = rsp.rvalid;
      rd    = rsp.rdata;
      rresp = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'h0;
      if (r) req.rready <= 1'h0;
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    check("irq", irq, 32'h0000_0000);
    check("drive", drv_n, 32'h0000_ffff);
    check("pins", pin, 32'h0000_0000);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      rdr(rows[i].addr);
      check("wresp", wresp, rows[i].resp);
      check("rresp", rresp, rows[i].resp);
      check("rdata", rd, rows[i].back);
      check("pins", pin[0], rows[i].pins);
    end
    check("drive0", drv_n[0], 32'h0000_0000);
    check("drive1", drv_n[1], 32'h0000_00ff);
    $display("test rows done");
    wr(12'h10c, 32'h0000_0002);
    wr(12'h100, 32'h0000_0003);
    rdr(12'h100);
    check("running", rd, 32'h0000_0003);
    check("start irq", m_cnt, 32'h0000_0001);
    rdr(12'h160);
    check("count", rd <= 32'h0000_0009, 32'h0000_0001);
    repeat (40) @(posedge aclk);
    check("start high", start_hi, 32'h0000_0001);
    check("master gap", m_gap, 32'h0000_000a);
    check("slave gap", s_gap, 32'h0000_0003);
    check("period", period_len, 32'h0000_000a);
    check("high", high_len, 32'h0000_0003);
    wr(12'h114, 32'h0000_0002);
    repeat (40) @(posedge aclk);
    check("high pol", high_len, 32'h0000_0007);
    wr(12'h144, 32'h0000_0004);
    repeat (40) @(posedge aclk);
    check("high duty", high_len, 32'h0000_0006);
    check("period duty", period_len, 32'h0000_000a);
    wr(12'h180, 32'h0000_0001);
    wr(12'h184, 32'h0000_0001);
    repeat (60) @(posedge aclk);
    check("period div", period_len, 32'h0000_0014);
    check("gap div", m_gap, 32'h0000_0014);
    $display("test pwm done");
    wr(12'h104, 32'h0000_0003);
    rdr(12'h100);
    check("stopped", rd, 32'h0000_0000);
    m_hold = m_cnt;
    repeat (40) @(posedge aclk);
    check("no irq", m_cnt, m_hold);
    $display("test stop done");
    // level write must be ignored while the timer owns the pin
    wr(12'h110, 32'h0000_0000);
    rdr(12'h110);
    check("level held", rd, 32'h0000_0002);
    // master on channel 4 fed from the slow clock must never tick
    wr(12'h108, 32'h0000_0002);
    wr(12'h150, 32'h0000_0005);
    wr(12'h190, 32'h0000_0010);
    wr(12'h100, 32'h0000_0010);
    repeat (60) @(posedge aclk);
    rdr(12'h170);
    check("no slow tick", rd, 32'h0000_0005);
    $display("test corner done");
    stop_test();
  end
endmodule
